/* monitor_regs_pkg.sv */
// Purpose: shared constants and carrier types for the monitor register bank upper part
// Assumes: one 40 MHz system clock, synchronous active-high power-on reset
// Notes:   offsets are the byte addresses seen by the management-bus engine
package monitor_regs_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] OFS_IRQ_MASK_GROUP_TWO         = 8'h44;
  localparam logic [7:0] OFS_CASE_OPEN_CLEAR            = 8'h46;
  localparam logic [7:0] OFS_CORE_CODE_AND_FAN_PRESCALE = 8'h47;
  localparam logic [7:0] OFS_CORE_CODE_MSB_AND_IDENT    = 8'h49;
  localparam logic [7:0] OFS_SECOND_CONFIGURATION       = 8'h4a;
  localparam logic [7:0] OFS_IRQ_FLAGS_ONE_COPY         = 8'h4c;
  localparam logic [7:0] OFS_IRQ_FLAGS_TWO_COPY         = 8'h4d;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned CLR_BIT          = 7;
  localparam int unsigned FAN_A_LSB        = 4;
  localparam int unsigned FAN_B_LSB        = 6;
  localparam int unsigned CFG_OVERTEMP_LINE_MASK   = 0;
  localparam int unsigned CFG_AMB_LOCK     = 1;
  localparam int unsigned CFG_REM_LOCK     = 2;
  localparam int unsigned CFG_ACPI_MODE    = 3;
  localparam int unsigned CFG_AUX_A_EN     = 6;
  localparam int unsigned CFG_AUX_B_EN     = 7;
  localparam int unsigned TWO_CASE_OPEN    = 4;
  localparam int unsigned TWO_OVERTEMP     = 5;
  localparam int unsigned TWO_DIODE_ONE    = 6;
  localparam int unsigned TWO_DIODE_TWO    = 7;
  localparam logic [7:0]  MASK_TWO_LIVE    = 8'hf3;
  localparam logic [7:0]  FLAGS_TWO_LIVE   = 8'hf3;
  localparam logic [7:0]  CFG_WRITABLE     = 8'hcf;
  localparam logic [7:0]  ONE_THERMAL_BITS = 8'h30;

  // ***************************************************************
  // reset values and identity
  // ***************************************************************
  localparam logic [7:0] RST_MASK_TWO     = 8'h00;
  localparam logic [7:0] RST_CONFIG_TWO   = 8'h00;
  localparam logic [3:0] RST_FAN_PRESCALE = 4'h0;
  localparam logic [7:0] RST_FLAGS        = 8'h00;
  // identity pattern value is arbitrary
  localparam logic [6:0] IDENT_PATTERN    = 7'h2a;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_HZ             = 40000000;
  localparam int unsigned CLEAR_PULSE_MS     = 20;
  localparam int unsigned CLEAR_PULSE_CYCLES = (CLEAR_PULSE_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned PULSE_CNT_W        = 20;

  typedef enum logic [1:0] {
    PULSE_IDLE    = 2'b00,
    PULSE_LOW     = 2'b01,
    PULSE_RELEASE = 2'b11
  } pulse_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] group_one;
    logic [1:0] volt_two;
    logic       overtemp_pulled_low;
    logic       diode_one_fault;
    logic       diode_two_fault;
  } monitor_cond_t;

endpackage

/* sticky_flag_bank.sv */
// Purpose: eight sticky status flags, set by conditions, cleared by a read
// Assumes: set and clear are synchronous to i_core_clk
// Notes:   a set in the clearing cycle wins so no event is lost
`timescale 1ns/100ps
module sticky_flag_bank
  import monitor_regs_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_set,
  input  wire logic [7:0] i_clear,
  output logic      [7:0] o_flags
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  assign flags_next = (flags_reg & ~i_clear) | i_set;
  assign o_flags    = flags_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) flags_reg <= RST_FLAGS;
    else flags_reg <= flags_next;
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_set_beats_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (|i_set) |=> ((o_flags & $past(i_set)) == $past(i_set)))
    else $error("flag set lost against clear");
  a_clear_empties: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_clear == 8'hff && i_set == 8'h00) |=> (o_flags == 8'h00))
    else $error("read did not clear flags");

endmodule

/* case_open_pulse.sv */
// Purpose: drives the case-open pin low for a fixed time after a clear request
// Assumes: start is a single-cycle request; requests while busy are ignored
// Notes:   one release cycle follows the low time before busy drops
`timescale 1ns/100ps
module case_open_pulse
  import monitor_regs_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = CLEAR_PULSE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_pin_oe_n
);

  pulse_state_t           state_reg;
  pulse_state_t           state_next;
  logic [PULSE_CNT_W-1:0] cnt_reg;
  logic                   oe_n_reg;
  logic                   cnt_done;

  assign cnt_done   = (cnt_reg == '0);
  assign o_busy     = (state_reg != PULSE_IDLE);
  assign o_pin_oe_n = oe_n_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PULSE_IDLE:    if (i_start) state_next = PULSE_LOW;
      PULSE_LOW:     if (cnt_done) state_next = PULSE_RELEASE;
      PULSE_RELEASE: state_next = PULSE_IDLE;
      default:       state_next = PULSE_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_reg <= PULSE_IDLE;
      cnt_reg   <= '0;
      oe_n_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      oe_n_reg  <= (state_next != PULSE_LOW);
      if (state_reg == PULSE_IDLE) cnt_reg <= PULSE_CNT_W'(PULSE_CYCLES - 1);
      else if (!cnt_done) cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [PULSE_CNT_W-1:0] low_len_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) low_len_reg <= '0;
    else if (!o_pin_oe_n) low_len_reg <= low_len_reg + 1'b1;
    else low_len_reg <= '0;
  end

  a_pulse_min_width: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_pin_oe_n) |-> (low_len_reg >= PULSE_CNT_W'(PULSE_CYCLES)))
    else $error("case-open low pulse too short");
  a_busy_ends_after: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(o_pin_oe_n) |-> o_busy ##1 !o_busy)
    else $error("clear bit did not drop after pulse");

endmodule

/* monitor_irq_mask_config_regs.sv */
// Purpose: mask, case-open clear, prescale, identity, config and status mirror registers
// Assumes: register strobes come from the management-bus engine, one cycle each
// Notes:   the status flags live here; the primary status registers read o_flags_*
`timescale 1ns/100ps
// Overview of operation
// - mask two bits 0,1,4-7 set keep matching group-two flags off interrupt
// - mask two bits 2,3 are plain read/write, zero after reset
// - writing clear bit 7 drives case-open pin low at least 20 ms
// - clear bit drops by itself once the low pulse ends
// - clear register bits 0-6 read zero
// - offset 0x47 bits 0-3 read the live lower core voltage code pins
// - 0x47 bits 5:4 set fan a prescale 1,2,4,8
// - 0x47 bits 7:6 set fan b prescale 1,2,4,8
// - 0x49 bit 0 reads the live core voltage code msb pin
// - 0x49 bits 1-7 read a fixed identity pattern, writes ignored
// - config bit 0 keeps thermal flags off interrupt, overtemp unaffected
// - config bit 1 written one locks ambient fan control until reset
// - config bit 2 written one locks remote fan control until reset
// - config bit 3 picks overtemp line mode: 0 default, 1 ACPI
// - config bit 6 enables aux pin a as active-high interrupt under channel mode
// - config bit 7 enables aux pin b likewise, zero after reset
// - config resets to zero; bits 4,5 reserved read-only
// - mirror one bits set on voltage or fan limit breach
// - mirror one bits 4,5 set on temperature interrupts or limits
// - mirror two bit 4 set when case-open input is high outside the clear low pulse
// - mirror two bit 5 external overtemp pull-low; bits 6,7 diode faults
// - reading status clears it; a still present condition sets it again
module monitor_irq_mask_config_regs
  import monitor_regs_pkg::*;
#(
  parameter int unsigned CLEAR_PULSE_LEN = CLEAR_PULSE_CYCLES
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_sys_rst,
  input  wire reg_req_t      i_reg_req,
  input  wire logic [1:0]    i_primary_status_rd,
  input  wire logic [7:0]    i_irq_mask_group_one,
  input  wire monitor_cond_t i_cond,
  input  wire logic [3:0]    i_core_voltage_code,
  input  wire logic          i_core_voltage_code_msb,
  input  wire logic          i_case_open_in,
  input  wire logic          i_chan_mode_irq,
  input  wire logic          i_aux_irq_a,
  input  wire logic          i_aux_irq_b,
  output logic [7:0]         o_reg_rdata,
  output logic               o_irq_n,
  output logic               o_case_open_out,
  output logic               o_case_open_oe_n,
  output logic [1:0]         o_fan_a_prescale,
  output logic [1:0]         o_fan_b_prescale,
  output logic               o_ambient_fan_lock,
  output logic               o_remote_fan_lock,
  output logic               o_overtemp_acpi_mode,
  output logic [7:0]         o_flags_one,
  output logic [7:0]         o_flags_two
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic hit(input reg_req_t req, input logic [7:0] ofs);
    hit = (req.addr == ofs);
  endfunction

  // ***************************************************************
  // storage
  // ***************************************************************
  logic [7:0] mask_two_reg;
  logic [7:0] mask_two_next;
  logic [3:0] prescale_reg;
  logic [3:0] prescale_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       irq_n_reg;
  logic       irq_n_next;
  logic       case_open_out_reg;

  // ***************************************************************
  // decode
  // ***************************************************************
  logic       wr_mask_two;
  logic       wr_clear;
  logic       wr_prescale;
  logic       wr_config;
  logic       rd_copy_one;
  logic       rd_copy_two;
  logic       clear_busy;
  logic       clear_start;
  logic       pin_oe_n;

  assign wr_mask_two = i_reg_req.wr && hit(i_reg_req, OFS_IRQ_MASK_GROUP_TWO);
  assign wr_clear    = i_reg_req.wr && hit(i_reg_req, OFS_CASE_OPEN_CLEAR);
  assign wr_prescale = i_reg_req.wr && hit(i_reg_req, OFS_CORE_CODE_AND_FAN_PRESCALE);
  assign wr_config   = i_reg_req.wr && hit(i_reg_req, OFS_SECOND_CONFIGURATION);
  assign rd_copy_one = i_reg_req.rd && hit(i_reg_req, OFS_IRQ_FLAGS_ONE_COPY);
  assign rd_copy_two = i_reg_req.rd && hit(i_reg_req, OFS_IRQ_FLAGS_TWO_COPY);

  // a request while the pulse runs is dropped rather than stretching it
  assign clear_start = wr_clear && i_reg_req.wdata[CLR_BIT] && !clear_busy;

  // ***************************************************************
  // next values of software registers
  // ***************************************************************
  assign mask_two_next = wr_mask_two ? i_reg_req.wdata : mask_two_reg;
  assign prescale_next = wr_prescale ? i_reg_req.wdata[7:4] : prescale_reg;

  // lock bits can only rise: a zero written later is ignored until reset
  always_comb begin
    config_next = config_reg;
    if (wr_config) begin
      config_next = (i_reg_req.wdata & CFG_WRITABLE);
      config_next[CFG_AMB_LOCK] = config_reg[CFG_AMB_LOCK] | i_reg_req.wdata[CFG_AMB_LOCK];
      config_next[CFG_REM_LOCK] = config_reg[CFG_REM_LOCK] | i_reg_req.wdata[CFG_REM_LOCK];
    end
  end

  // ***************************************************************
  // status flags
  // ***************************************************************
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] clr_one;
  logic [7:0] clr_two;
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic       case_open_seen;

  // while we pull the pin low ourselves its level says nothing about the case
  assign case_open_seen = i_case_open_in && pin_oe_n;
  assign set_one = i_cond.group_one;
  assign set_two = {i_cond.diode_two_fault, i_cond.diode_one_fault,
                    i_cond.overtemp_pulled_low, case_open_seen,
                    2'b00, i_cond.volt_two} & FLAGS_TWO_LIVE;
  // primary and copy share one store, so they cannot disagree
  assign clr_one = {8{rd_copy_one | i_primary_status_rd[0]}};
  assign clr_two = {8{rd_copy_two | i_primary_status_rd[1]}};

  sticky_flag_bank u_flags_one (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_set      (set_one),
    .i_clear    (clr_one),
    .o_flags    (flags_one)
  );

  sticky_flag_bank u_flags_two (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_set      (set_two),
    .i_clear    (clr_two),
    .o_flags    (flags_two)
  );

  // ***************************************************************
  // case-open clear pulse
  // ***************************************************************
  case_open_pulse #(
    .PULSE_CYCLES (CLEAR_PULSE_LEN)
  ) u_case_open_pulse (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (clear_start),
    .o_busy     (clear_busy),
    .o_pin_oe_n (pin_oe_n)
  );

  // ***************************************************************
  // interrupt combine
  // ***************************************************************
  logic [7:0] one_gate;
  logic       pend_one;
  logic       pend_two;
  logic       aux_pend;

  // thermal mask only affects the interrupt line, never the overtemp line
  assign one_gate = ~i_irq_mask_group_one
                    & ~(config_reg[CFG_OVERTEMP_LINE_MASK] ? ONE_THERMAL_BITS : 8'h00);
  assign pend_one = |(flags_one & one_gate);
  assign pend_two = |(flags_two & ~mask_two_reg & MASK_TWO_LIVE);
  assign aux_pend = i_chan_mode_irq
                    && ((config_reg[CFG_AUX_A_EN] && i_aux_irq_a)
                     || (config_reg[CFG_AUX_B_EN] && i_aux_irq_b));
  assign irq_n_next = !(pend_one || pend_two || aux_pend);

  // ***************************************************************
  // read mux
  // ***************************************************************
  always_comb begin
    rdata_next = 8'h00;
    if (hit(i_reg_req, OFS_IRQ_MASK_GROUP_TWO)) rdata_next = mask_two_reg;
    else if (hit(i_reg_req, OFS_CASE_OPEN_CLEAR)) rdata_next = {clear_busy, 7'h00};
    else if (hit(i_reg_req, OFS_CORE_CODE_AND_FAN_PRESCALE))
      rdata_next = {prescale_reg, i_core_voltage_code};
    else if (hit(i_reg_req, OFS_CORE_CODE_MSB_AND_IDENT))
      rdata_next = {IDENT_PATTERN, i_core_voltage_code_msb};
    else if (hit(i_reg_req, OFS_SECOND_CONFIGURATION)) rdata_next = config_reg;
    else if (hit(i_reg_req, OFS_IRQ_FLAGS_ONE_COPY)) rdata_next = flags_one;
    else if (hit(i_reg_req, OFS_IRQ_FLAGS_TWO_COPY)) rdata_next = flags_two;
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mask_two_reg <= RST_MASK_TWO;
      prescale_reg <= RST_FAN_PRESCALE;
      config_reg   <= RST_CONFIG_TWO;
      irq_n_reg    <= 1'b1;
    end else begin
      mask_two_reg <= mask_two_next;
      prescale_reg <= prescale_next;
      config_reg   <= config_next;
      irq_n_reg    <= irq_n_next;
    end
  end

  // read data holds until the next read so the bus engine can sample late
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) rdata_reg <= 8'h00;
    else if (i_reg_req.rd) rdata_reg <= rdata_next;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) case_open_out_reg <= 1'b0;
    else case_open_out_reg <= 1'b0;
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_reg_rdata          = rdata_reg;
  assign o_irq_n              = irq_n_reg;
  assign o_case_open_out      = case_open_out_reg;
  assign o_case_open_oe_n     = pin_oe_n;
  assign o_fan_a_prescale     = prescale_reg[FAN_A_LSB-4 +: 2];
  assign o_fan_b_prescale     = prescale_reg[FAN_B_LSB-4 +: 2];
  assign o_ambient_fan_lock   = config_reg[CFG_AMB_LOCK];
  assign o_remote_fan_lock    = config_reg[CFG_REM_LOCK];
  assign o_overtemp_acpi_mode = config_reg[CFG_ACPI_MODE];
  assign o_flags_one          = flags_one;
  assign o_flags_two          = flags_two;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_mask_two_gates: assert property (
    (flags_two[TWO_DIODE_ONE] && !mask_two_reg[TWO_DIODE_ONE]) |=> !o_irq_n)
    else $error("unmasked group two flag did not raise interrupt");

  a_mask_two_blocks: assert property (
    (flags_one == 8'h00 && !aux_pend && (flags_two & ~mask_two_reg & MASK_TWO_LIVE) == 8'h00)
      |=> o_irq_n)
    else $error("masked group two flag raised interrupt");

  a_reserved_mask_rw: assert property (
    wr_mask_two |=> (mask_two_reg[3:2] == $past(i_reg_req.wdata[3:2])))
    else $error("reserved mask bits not writable");

  a_clear_low_zero: assert property (
    (i_reg_req.rd && hit(i_reg_req, OFS_CASE_OPEN_CLEAR)) |=> (o_reg_rdata[6:0] == 7'h00))
    else $error("clear register low bits not zero");

  a_clear_starts_pulse: assert property (
    clear_start |=> (!o_case_open_oe_n && o_reg_rdata == $past(o_reg_rdata)))
    else $error("clear write did not start pulse");

  a_busy_reads_set: assert property (
    (i_reg_req.rd && hit(i_reg_req, OFS_CASE_OPEN_CLEAR))
      |=> (o_reg_rdata[CLR_BIT] == $past(clear_busy)))
    else $error("clear bit does not follow pulse");

  a_code_live_read: assert property (
    (i_reg_req.rd && hit(i_reg_req, OFS_CORE_CODE_AND_FAN_PRESCALE))
      |=> (o_reg_rdata[3:0] == $past(i_core_voltage_code)))
    else $error("core code read not live");

  a_prescale_write: assert property (
    wr_prescale |=> (o_fan_a_prescale == $past(i_reg_req.wdata[5:4])
                     && o_fan_b_prescale == $past(i_reg_req.wdata[7:6])))
    else $error("prescale fields not written");

  a_ident_fixed: assert property (
    (i_reg_req.rd && hit(i_reg_req, OFS_CORE_CODE_MSB_AND_IDENT))
      |=> (o_reg_rdata == {IDENT_PATTERN, $past(i_core_voltage_code_msb)}))
    else $error("identity read wrong");

  a_overtemp_line_mask_only: assert property (
    (config_reg[CFG_OVERTEMP_LINE_MASK] && flags_one == ONE_THERMAL_BITS && !aux_pend
     && (flags_two & ~mask_two_reg & MASK_TWO_LIVE) == 8'h00) |=> o_irq_n)
    else $error("masked thermal flag raised interrupt");

  a_lock_sticky: assert property (
    o_ambient_fan_lock |=> o_ambient_fan_lock [*2])
    else $error("ambient lock released");

  a_remote_lock_held: assert property (
    o_remote_fan_lock |=> o_remote_fan_lock)
    else $error("remote lock released");

  a_acpi_write: assert property (
    wr_config |=> (o_overtemp_acpi_mode == $past(i_reg_req.wdata[CFG_ACPI_MODE])))
    else $error("overtemp mode bit not written");

  a_aux_needs_mode: assert property (
    (!i_chan_mode_irq && flags_one == 8'h00 && flags_two == 8'h00) |=> o_irq_n)
    else $error("aux input raised interrupt outside channel mode");

  a_aux_b_raises: assert property (
    (i_chan_mode_irq && config_reg[CFG_AUX_B_EN] && i_aux_irq_b) |=> !o_irq_n)
    else $error("aux input b did not raise interrupt");

  a_cfg_reserved_zero: assert property (
    wr_config |=> (config_reg[5:4] == 2'b00 && o_remote_fan_lock >= $past(o_remote_fan_lock)))
    else $error("config reserved bits or lock wrong");

  a_copy_read_clears: assert property (
    (rd_copy_two && set_two == 8'h00) |=> (o_flags_two == 8'h00))
    else $error("status copy read did not clear");

  a_primary_clears: assert property (
    (i_primary_status_rd[0] && set_one == 8'h00) |=> (o_flags_one == 8'h00))
    else $error("primary status read did not clear");

  a_copy_one_read: assert property (
    rd_copy_one |=> (o_reg_rdata == $past(flags_one)))
    else $error("status copy one read wrong");

  a_case_open_flag: assert property (
    (i_case_open_in && pin_oe_n) |=> o_flags_two[TWO_CASE_OPEN])
    else $error("case-open flag not set");

  c_clear_pulse: cover property (clear_start ##1 clear_busy);
  c_aux_irq: cover property (aux_pend ##1 !o_irq_n);
  c_read_reset: cover property (rd_copy_one && flags_one != 8'h00);
  c_lock_write: cover property (wr_config && i_reg_req.wdata[CFG_AMB_LOCK]);
  c_primary_clear: cover property (i_primary_status_rd[0] && flags_one != 8'h00);

endmodule

/* mgmt_host_model.sv */
// Purpose: management-bus host stand-in issuing single-byte register accesses
// Assumes: requests change at the falling edge, one cycle each
// Notes:   released address and data show inverted values, never stale ones
`timescale 1ns/100ps
module mgmt_host_model
  import monitor_regs_pkg::*;
(
  input  wire logic i_core_clk,
  output reg_req_t  o_req
);
  // ***************************************************************
  // access task
  // ***************************************************************
  initial o_req = '0;
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge i_core_clk);
    o_req.addr  = a;
    o_req.wr    = w;
    o_req.rd    = !w;
    o_req.wdata = d;
    @(negedge i_core_clk);
    o_req.wr    = 1'b0;
    o_req.rd    = 1'b0;
    // inverted so a design that samples late sees garbage, not the old byte
    o_req.addr  = ~a;
    o_req.wdata = ~d;
  endtask
endmodule

/* monitor_irq_mask_config_regs_tb_top.sv */
// Purpose: self-checking bench for the upper monitor register bank
// Assumes: inputs change on the falling edge of i_core_clk
// Notes:   pulse length shortened to 8 cycles to keep the run short
`timescale 1ns/100ps
module monitor_irq_mask_config_regs_tb_top;
  import monitor_regs_pkg::*;
  // ***************************************************************
  // signals and instances
  // ***************************************************************
  localparam int unsigned PLEN = 8;
  logic          i_core_clk = 1'b0;
  logic          i_sys_rst  = 1'b1;
  reg_req_t      req;
  monitor_cond_t cond;
  logic [3:0]    code;
  logic [1:0]    aux, fa, fb, prd;
  logic [7:0]    rdata, fl1, fl2;
  logic          msb, ext_open, irq_n, co_out, co_oe_n, alock, rlock, acpi, chm;
  int            err_count = 0, cmp_count = 0, cyc = 0, lowc;
  // external level wins only while the device is not pulling the pin
  wire           case_pin = co_oe_n ? ext_open : co_out;
  always #12.5 i_core_clk = ~i_core_clk;
  mgmt_host_model host (.i_core_clk(i_core_clk), .o_req(req));
  monitor_irq_mask_config_regs #(.CLEAR_PULSE_LEN(PLEN)) dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_req(req),
    .i_primary_status_rd(prd), .i_irq_mask_group_one(8'h00), .i_cond(cond),
    .i_core_voltage_code(code), .i_core_voltage_code_msb(msb), .i_case_open_in(case_pin),
    .i_chan_mode_irq(chm), .i_aux_irq_a(aux[0]), .i_aux_irq_b(aux[1]),
    .o_reg_rdata(rdata), .o_irq_n(irq_n), .o_case_open_out(co_out),
    .o_case_open_oe_n(co_oe_n), .o_fan_a_prescale(fa), .o_fan_b_prescale(fb),
    .o_ambient_fan_lock(alock), .o_remote_fan_lock(rlock), .o_overtemp_acpi_mode(acpi),
    .o_flags_one(fl1), .o_flags_two(fl2));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.access(a, 1'b0, 8'h00);
    chk("rdata", e, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(a, 1'b1, d);
  endtask
  task automatic pulse_cond(input monitor_cond_t c, input logic o);
    cond = c;
    ext_open = o;
    @(negedge i_core_clk);
    cond = '0;
    ext_open = 1'b0;
    repeat (2) @(negedge i_core_clk);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  // ***************************************************************
  // sequence
  // ***************************************************************
  initial begin
    cond = '0;
    code = 4'h5;
    msb = 1'b1;
    prd = 2'b00;
    chm = 1'b1;
    ext_open = 1'b0;
    aux = 2'b00;
    repeat (6) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    rd(OFS_IRQ_MASK_GROUP_TWO, RST_MASK_TWO);
    rd(OFS_CASE_OPEN_CLEAR, 8'h00);
    rd(OFS_SECOND_CONFIGURATION, RST_CONFIG_TWO);
    rd(OFS_IRQ_FLAGS_TWO_COPY, RST_FLAGS);
    rd(OFS_CORE_CODE_AND_FAN_PRESCALE, 8'h05);
    wr(OFS_CORE_CODE_MSB_AND_IDENT, 8'h00);
    rd(OFS_CORE_CODE_MSB_AND_IDENT, {IDENT_PATTERN, 1'b1});
    msb = 1'b0;
    rd(OFS_CORE_CODE_MSB_AND_IDENT, {IDENT_PATTERN, 1'b0});
    rd(8'h48, 8'h00);
    for (int k = 0; k < 4; k++) begin
      code = 4'(k * 5);
      wr(OFS_CORE_CODE_AND_FAN_PRESCALE, {2'(3 - k), 2'(k), 4'h0});
      chk("fan_a", 8'(k), {6'h0, fa});
      chk("fan_b", 8'(3 - k), {6'h0, fb});
      rd(OFS_CORE_CODE_AND_FAN_PRESCALE, {2'(3 - k), 2'(k), 4'(k * 5)});
    end
    pulse_cond('{group_one: 8'h41, default: '0}, 1'b0);
    chk("irq_n", 8'h00, {7'h0, irq_n});
    rd(OFS_IRQ_FLAGS_ONE_COPY, 8'h41);
    rd(OFS_IRQ_FLAGS_ONE_COPY, 8'h00);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    pulse_cond('{group_one: 8'h02, default: '0}, 1'b0);
    chk("flags_one", 8'h02, fl1);
    prd = 2'b01;
    @(negedge i_core_clk);
    prd = 2'b00;
    chk("flags_one", 8'h00, fl1);
    wr(OFS_SECOND_CONFIGURATION, 8'h01);
    pulse_cond('{group_one: 8'h30, default: '0}, 1'b0);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    rd(OFS_IRQ_FLAGS_ONE_COPY, 8'h30);
    pulse_cond('{overtemp_pulled_low: 1'b1, diode_two_fault: 1'b1, default: '0}, 1'b1);
    chk("irq_n", 8'h00, {7'h0, irq_n});
    chk("flags_two", 8'hb0, fl2);
    rd(OFS_IRQ_FLAGS_TWO_COPY, 8'hb0);
    wr(OFS_IRQ_MASK_GROUP_TWO, 8'hff);
    rd(OFS_IRQ_MASK_GROUP_TWO, 8'hff);
    pulse_cond('{diode_one_fault: 1'b1, default: '0}, 1'b0);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    rd(OFS_IRQ_FLAGS_TWO_COPY, 8'h40);
    wr(OFS_SECOND_CONFIGURATION, 8'hff);
    rd(OFS_SECOND_CONFIGURATION, CFG_WRITABLE);
    chk("cfg_out", 8'h07, {5'h0, acpi, rlock, alock});
    chm = 1'b0;
    aux = 2'b11;
    repeat (2) @(negedge i_core_clk);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    chm = 1'b1;
    for (int j = 1; j < 3; j++) begin
      aux = 2'(j);
      repeat (2) @(negedge i_core_clk);
      chk("irq_n", 8'h00, {7'h0, irq_n});
      aux = 2'b00;
      repeat (2) @(negedge i_core_clk);
    end
    wr(OFS_SECOND_CONFIGURATION, 8'h00);
    rd(OFS_SECOND_CONFIGURATION, 8'h06);
    wr(OFS_CASE_OPEN_CLEAR, 8'hff);
    rd(OFS_CASE_OPEN_CLEAR, 8'h80);
    chk("case_out", 8'h00, {7'h0, co_out});
    lowc = 0;
    while (co_oe_n === 1'b0 && lowc < 100) begin
      @(negedge i_core_clk);
      lowc++;
    end
    chk("pulse_long", 8'h01, {7'h0, lowc + 2 >= PLEN});
    repeat (3) @(negedge i_core_clk);
    rd(OFS_CASE_OPEN_CLEAR, 8'h00);
    end_of_test();
  end
endmodule
